/* File: epbuf_pkg.sv */
// Shared constants and state types for the endpoint buffer command engine.
package epbuf_pkg;
  localparam int EP_COUNT = 16;
  localparam int EP_IDX_W = 4;
  localparam int PTR_W = 10;
  localparam int SIZE_W = 10;
  localparam int DATA_W = 16;
  localparam int MEM_ADDR_W = EP_IDX_W + 1 + PTR_W;
  localparam int MEM_WORDS = 1 << MEM_ADDR_W;

  // Command codes on the low data byte.
  localparam logic [7:0] CMD_WRITE_FIRST = 8'h01;
  localparam logic [7:0] CMD_WRITE_LAST = 8'h0F;
  localparam logic [7:0] CMD_READ_CTRL = 8'h10;
  localparam logic [7:0] CMD_READ_FIRST = 8'h12;
  localparam logic [7:0] CMD_READ_LAST = 8'h1F;
  localparam logic [7:0] CMD_STAT_FIRST = 8'h50;
  localparam logic [7:0] CMD_STAT_LAST = 8'h5F;

  // Largest buffer size in bytes per endpoint type.
  localparam logic [SIZE_W-1:0] ISO_MAX_BYTES = 10'h3FF;
  localparam logic [SIZE_W-1:0] BULK_MAX_BYTES = 10'h020;

  // Buffer word layout: word 0 holds the packet length.
  localparam logic [PTR_W-1:0] LEN_WORD = 10'h000;
  localparam logic [PTR_W-1:0] FIRST_DATA_WORD = 10'h001;

  // Status byte fields.
  localparam int ST_HALT_BIT = 7;
  localparam int ST_FULL1_BIT = 6;
  localparam int ST_FULL0_BIT = 5;
  localparam int ST_TOGGLE_BIT = 4;
  localparam int ST_OVERRUN_BIT = 3;
  localparam int ST_SETUP_BIT = 2;
  localparam int ST_CPU_BUFFER_SELECT_BIT = 1;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  typedef enum logic [3:0] {
    MODE_IDLE = 4'b0001,
    MODE_WRITE = 4'b0010,
    MODE_READ = 4'b0100,
    MODE_STATUS = 4'b1000
  } cpu_mode_t;

  typedef enum logic [3:0] {
    DMA_IDLE = 4'b0001,
    DMA_LOAD = 4'b0010,
    DMA_RUN = 4'b0100,
    DMA_CLOSE = 4'b1000
  } dma_state_t;
endpackage

/* File: ep_status_bank.sv */
// Per-endpoint status byte flags for all sixteen endpoint slots.
`timescale 1ns/10ps
module ep_status_bank (
  input wire logic clk_sys, // system clock
  input wire logic arst_n, // async reset, active low
  input wire logic clkEn, // clock enable
  input wire logic [15:0] haltSet, // stall command per endpoint
  input wire logic [15:0] haltClr, // unstall command per endpoint
  input wire logic [15:0] setupTok, // setup token arrived
  input wire logic [15:0] full0Set, // primary buffer became full
  input wire logic [15:0] full0Clr, // primary buffer emptied
  input wire logic [15:0] full1Set, // secondary buffer became full
  input wire logic [15:0] full1Clr, // secondary buffer emptied
  input wire logic [15:0] toggleFlip, // data toggle advances
  input wire logic [15:0] setupStore, // setup packet stored
  input wire logic [15:0] setupAck, // setup acknowledged
  input wire logic [15:0] overrunSet, // setup data overwritten
  input wire logic [15:0] setupWriteBusy, // setup data still being written
  input wire logic [15:0] bufSwitch, // flip cpu buffer select
  input wire logic [15:0] readClear, // status byte read
  output logic [127:0] statusFlat // eight bits per endpoint
);
  genvar gi;
  generate
    for (gi = 0; gi < epbuf_pkg::EP_COUNT; gi++) begin : g_ep
      logic [7:0] st_reg;
      always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
          st_reg <= epbuf_pkg::STATUS_RESET;
        end else if (clkEn) begin
          if (haltSet[gi]) begin
            st_reg[epbuf_pkg::ST_HALT_BIT] <= 1'b1;
          end else if (haltClr[gi] || setupTok[gi]) begin
            st_reg[epbuf_pkg::ST_HALT_BIT] <= 1'b0;
          end
          if (full1Set[gi]) begin
            st_reg[epbuf_pkg::ST_FULL1_BIT] <= 1'b1;
          end else if (full1Clr[gi]) begin
            st_reg[epbuf_pkg::ST_FULL1_BIT] <= 1'b0;
          end
          if (full0Set[gi]) begin
            st_reg[epbuf_pkg::ST_FULL0_BIT] <= 1'b1;
          end else if (full0Clr[gi]) begin
            st_reg[epbuf_pkg::ST_FULL0_BIT] <= 1'b0;
          end
          // Re-initialising an endpoint restarts its toggle at DATA0.
          if (haltClr[gi] || setupTok[gi]) begin
            st_reg[epbuf_pkg::ST_TOGGLE_BIT] <= 1'b0;
          end else if (toggleFlip[gi]) begin
            st_reg[epbuf_pkg::ST_TOGGLE_BIT] <= ~st_reg[epbuf_pkg::ST_TOGGLE_BIT];
          end
          // A new overrun in the read cycle wins over the clear.
          if (overrunSet[gi]) begin
            st_reg[epbuf_pkg::ST_OVERRUN_BIT] <= 1'b1;
          end else if (readClear[gi] && !setupWriteBusy[gi]) begin
            st_reg[epbuf_pkg::ST_OVERRUN_BIT] <= 1'b0;
          end
          if (setupStore[gi]) begin
            st_reg[epbuf_pkg::ST_SETUP_BIT] <= 1'b1;
          end else if (setupAck[gi]) begin
            st_reg[epbuf_pkg::ST_SETUP_BIT] <= 1'b0;
          end
          if (bufSwitch[gi]) begin
            st_reg[epbuf_pkg::ST_CPU_BUFFER_SELECT_BIT] <= ~st_reg[epbuf_pkg::ST_CPU_BUFFER_SELECT_BIT];
          end
          st_reg[0] <= 1'b0;
        end
      end
      assign statusFlat[gi*8 +: 8] = st_reg;
    end
  endgenerate
endmodule

/* File: ep_buffer_mem.sv */
// Endpoint buffer memory with a local port and a serial engine port.
`timescale 1ns/10ps
module ep_buffer_mem (
  input wire logic clk_sys, // system clock
  input wire logic arst_n, // async reset, active low
  input wire logic clkEn, // clock enable
  input wire logic [14:0] locAddr, // local word address
  input wire logic locWe, // local write strobe
  input wire logic [15:0] locWrData, // local write data
  output logic [15:0] locRdData, // local read data, combinational
  input wire logic [14:0] sieAddr, // serial engine word address
  input wire logic sieWe, // serial engine write strobe
  input wire logic [15:0] sieWrData, // serial engine write data
  output logic [15:0] sieRdData // serial engine read data, registered
);
  logic [15:0] mem [epbuf_pkg::MEM_WORDS];

  // The serial engine write goes last so it wins on an address clash.
  always_ff @(posedge clk_sys) begin
    if (clkEn) begin
      if (locWe) begin
        mem[locAddr] <= locWrData;
      end
      if (sieWe) begin
        mem[sieAddr] <= sieWrData;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sieRdData <= 16'h0000;
    end else if (clkEn) begin
      sieRdData <= mem[sieAddr];
    end
  end

  assign locRdData = mem[locAddr];
endmodule

/* File: epbuf_cmd_engine.sv */
// Endpoint buffer command interpreter: command/data port, DMA access and status reads.
//
// Contract
// - Write codes 01h-0Fh select control IN and endpoints 1-14.
// - Read codes 10h and 12h-1Fh select control OUT and endpoints 1-14.
// - A buffer command resets the endpoint pointer to the buffer start.
// - At most N+2 bytes, M+1 words, move after a buffer command.
// - Each data read or write advances the pointer by one word; the code holds the pointer once it is past the last buffer word.
// - Word 0 holds packet length; later words hold byte pairs, odd byte low.
// - DMA skips the length word and starts at the second word.
// - Buffer reads flag the last word from the packet length.
// - Bulk buffers go out only when full, or early on transfer end.
// - Buffer sizes reach 1023 bytes isochronous, 32 bytes bulk or interrupt.
// - Select high carries a command on the low byte; low carries data.
// - DMA on a double-buffered endpoint moves on to the other buffer.
// - Codes 50h-5Fh return the selected endpoint status byte.
// - Reading a status byte clears that endpoint interrupt source bit.
// - Status bit 7 is halt: set by stall, cleared by unstall or setup.
// - Status bits 6 and 5 show secondary and primary buffer full.
// - Status bit 4 gives the next data toggle.
// - Bit 3 sets on setup overrun, clears on read once setup writing ends.
// - Bit 2 shows setup held, bit 1 cpu buffer, bit 0 reserved.
`timescale 1ns/10ps
module epbuf_cmd_engine (
  input wire logic clk_sys, // system clock, 40 MHz
  input wire logic arst_n, // async reset, active low
  input wire logic clkEn, // clock enable, freezes all state when low
  input wire logic commandDataSelect, // high: command phase, low: data phase
  input wire logic busWrite, // one-cycle write strobe on the port
  input wire logic busRead, // one-cycle read strobe on the port
  input wire logic [15:0] busDataIn, // port write data
  output logic [15:0] busDataOut, // port read data
  output logic busReadValid, // pulse: busDataOut just updated
  output logic busEndOfPacket, // level: busDataOut holds the last packet word
  input wire logic [159:0] epSizeFlat, // ten-bit buffer size in bytes per endpoint
  input wire logic [15:0] epIsoMask, // endpoint is isochronous
  input wire logic [15:0] epDoubleMask, // endpoint is double buffered
  input wire logic dmaStart, // pulse: begin a DMA transfer
  input wire logic dmaToBuffer, // DMA direction: 1 writes an IN buffer
  input wire logic [3:0] dmaEndpoint, // endpoint slot for DMA
  input wire logic dmaReq, // DMA agent requests one word
  input wire logic [15:0] dmaDataIn, // DMA write data
  input wire logic transferEndSignal, // external end of DMA transfer
  output logic [15:0] dmaDataOut, // DMA read data
  output logic dmaAck, // pulse: one DMA word moved
  output logic dmaLast, // pulse with dmaAck on the last packet word
  output logic dmaBusy, // level: DMA transfer in progress
  output logic [15:0] intSourceClear, // pulse: clear interrupt source bit
  output logic sendReq, // pulse: buffer ready to go to the host
  output logic [3:0] sendEndpoint, // endpoint of sendReq
  output logic sendBuffer, // buffer of sendReq, 0 primary
  input wire logic [14:0] sieAddr, // serial engine word address
  input wire logic sieWe, // serial engine write strobe
  input wire logic [15:0] sieWrData, // serial engine write data
  output logic [15:0] sieRdData, // serial engine read data
  input wire logic [15:0] haltSetEv, // stall command per endpoint
  input wire logic [15:0] haltClrEv, // unstall command per endpoint
  input wire logic [15:0] setupTokEv, // setup token per endpoint
  input wire logic [15:0] full0SetEv, // primary filled by serial engine
  input wire logic [15:0] full0ClrEv, // primary emptied
  input wire logic [15:0] full1SetEv, // secondary filled by serial engine
  input wire logic [15:0] full1ClrEv, // secondary emptied
  input wire logic [15:0] toggleFlipEv, // data toggle advanced
  input wire logic [15:0] setupStoreEv, // setup packet stored
  input wire logic [15:0] setupAckEv, // setup acknowledged
  input wire logic [15:0] overrunEv, // setup overwritten
  input wire logic [15:0] setupWriteBusy, // setup write in progress
  input wire logic [15:0] bufSwitchEv // cpu buffer select flips
);
  epbuf_pkg::cpu_mode_t cpuMode_reg;
  epbuf_pkg::dma_state_t dmaState_reg;
  logic [3:0] cpuEp_reg;
  logic [9:0] cpuPtr_reg;
  logic [15:0] cpuLen_reg;
  logic [3:0] dmaEp_reg;
  logic dmaBuf_reg;
  logic dmaDir_reg;
  logic [9:0] dmaPtr_reg;
  logic [15:0] dmaLen_reg;
  logic dmaEot_reg;
  logic [127:0] statusFlat;
  logic [15:0] locRdData;
  logic [14:0] locAddr;
  logic locWe;
  logic [15:0] locWrData;
  logic [7:0] cmdCode;
  logic isWrCmd;
  logic isRdCmd;
  logic isStatCmd;
  logic cmdTaken;
  logic cpuWrite;
  logic cpuRead;
  logic cpuStatRead;
  logic cpuAccess;
  logic cpuInRange;
  logic cpu_buffer_select;
  logic dmaGrant;
  logic dmaPortFree;
  logic dmaEndOfBuf;
  logic dmaEndOfPkt;
  logic dmaDouble;
  logic [9:0] cpuLastWord;
  logic [9:0] dmaLastWord;
  logic [9:0] dmaWordsDone;
  logic [15:0] statusClear;
  logic [15:0] fill0;
  logic [15:0] fill1;

  // Clamp the configured size to what the endpoint type allows.
  function automatic logic [9:0] lastWordOf(input logic [9:0] size, input logic iso);
    logic [9:0] n;
    n = size;
    if (iso && size > epbuf_pkg::ISO_MAX_BYTES) begin
      n = epbuf_pkg::ISO_MAX_BYTES;
    end else if (!iso && size > epbuf_pkg::BULK_MAX_BYTES) begin
      n = epbuf_pkg::BULK_MAX_BYTES;
    end
    lastWordOf = 10'((11'(n) + 11'h001) >> 1);
  endfunction

  // Word index that carries the final byte of a packet of len bytes.
  function automatic logic [9:0] pktLastWord(input logic [15:0] len);
    pktLastWord = 10'((17'(len) + 17'h00001) >> 1);
  endfunction

  assign cmdCode = busDataIn[7:0];
  assign isWrCmd = cmdCode >= epbuf_pkg::CMD_WRITE_FIRST && cmdCode <= epbuf_pkg::CMD_WRITE_LAST;
  assign isRdCmd = cmdCode == epbuf_pkg::CMD_READ_CTRL
                   || (cmdCode >= epbuf_pkg::CMD_READ_FIRST && cmdCode <= epbuf_pkg::CMD_READ_LAST);
  assign isStatCmd = cmdCode >= epbuf_pkg::CMD_STAT_FIRST && cmdCode <= epbuf_pkg::CMD_STAT_LAST;
  assign cmdTaken = busWrite && commandDataSelect;
  assign cpuWrite = busWrite && !commandDataSelect && cpuMode_reg == epbuf_pkg::MODE_WRITE;
  assign cpuRead = busRead && !commandDataSelect && cpuMode_reg == epbuf_pkg::MODE_READ;
  assign cpuStatRead = busRead && !commandDataSelect && cpuMode_reg == epbuf_pkg::MODE_STATUS;
  assign cpuAccess = cpuWrite || cpuRead;
  assign cpu_buffer_select = statusFlat[cpuEp_reg*8 + epbuf_pkg::ST_CPU_BUFFER_SELECT_BIT];
  assign cpuLastWord = lastWordOf(epSizeFlat[cpuEp_reg*10 +: 10], epIsoMask[cpuEp_reg]);
  assign cpuInRange = cpuPtr_reg <= cpuLastWord;
  assign dmaDouble = epDoubleMask[dmaEp_reg];
  assign dmaLastWord = lastWordOf(epSizeFlat[dmaEp_reg*10 +: 10], epIsoMask[dmaEp_reg]);
  // The processor port has priority; the DMA agent waits for its acknowledge.
  assign dmaPortFree = !cpuAccess;
  // A word offered with the end signal is neither stored nor acknowledged, so the agent keeps it.
  assign dmaGrant = dmaReq && dmaPortFree && !transferEndSignal && dmaState_reg == epbuf_pkg::DMA_RUN;
  assign dmaEndOfBuf = dmaPtr_reg >= dmaLastWord;
  assign dmaEndOfPkt = dmaPtr_reg >= pktLastWord(dmaLen_reg) || dmaEndOfBuf;
  assign dmaWordsDone = (dmaGrant && dmaDir_reg) ? dmaPtr_reg : 10'(dmaPtr_reg - epbuf_pkg::FIRST_DATA_WORD);
  // One shared local memory port: processor first, then DMA length write, then DMA length read, then DMA data.
  always_comb begin
    locAddr = {cpuEp_reg, cpu_buffer_select, cpuPtr_reg};
    locWe = 1'b0;
    locWrData = busDataIn;
    if (cpuAccess) begin
      locWe = cpuWrite && cpuInRange;
    end else if (dmaState_reg == epbuf_pkg::DMA_CLOSE) begin
      locAddr = {dmaEp_reg, dmaBuf_reg, epbuf_pkg::LEN_WORD};
      locWe = 1'b1;
      locWrData = dmaLen_reg;
    end else if (dmaState_reg == epbuf_pkg::DMA_LOAD) begin
      locAddr = {dmaEp_reg, dmaBuf_reg, epbuf_pkg::LEN_WORD};
    end else begin
      locAddr = {dmaEp_reg, dmaBuf_reg, dmaPtr_reg};
      locWe = dmaGrant && dmaDir_reg;
      locWrData = dmaDataIn;
    end
  end

  // Processor command and pointer handling.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cpuMode_reg <= epbuf_pkg::MODE_IDLE;
      cpuEp_reg <= 4'h0;
      cpuPtr_reg <= epbuf_pkg::LEN_WORD;
    end else if (clkEn) begin
      if (cmdTaken) begin
        cpuEp_reg <= cmdCode[3:0];
        cpuPtr_reg <= epbuf_pkg::LEN_WORD;
        if (isWrCmd) begin
          cpuMode_reg <= epbuf_pkg::MODE_WRITE;
        end else if (isRdCmd) begin
          cpuMode_reg <= epbuf_pkg::MODE_READ;
        end else if (isStatCmd) begin
          cpuMode_reg <= epbuf_pkg::MODE_STATUS;
        end else begin
          cpuMode_reg <= epbuf_pkg::MODE_IDLE;
        end
      end else if (cpuAccess && cpuInRange) begin
        cpuPtr_reg <= 10'(cpuPtr_reg + 10'h001);
      end
    end
  end

  // Processor read data, packet length capture and end-of-packet marking.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      busDataOut <= 16'h0000;
      busReadValid <= 1'b0;
      busEndOfPacket <= 1'b0;
      cpuLen_reg <= 16'h0000;
    end else if (clkEn) begin
      busReadValid <= cpuRead || cpuStatRead;
      if (cpuRead) begin
        busDataOut <= cpuInRange ? locRdData : 16'h0000;
        if (cpuPtr_reg == epbuf_pkg::LEN_WORD) begin
          cpuLen_reg <= locRdData;
          busEndOfPacket <= locRdData == 16'h0000;
        end else begin
          busEndOfPacket <= cpuPtr_reg == pktLastWord(cpuLen_reg);
        end
      end else if (cpuStatRead) begin
        busDataOut <= {8'h00, statusFlat[cpuEp_reg*8 +: 8]};
        busEndOfPacket <= 1'b0;
      end
    end
  end

  // Interrupt source clear and the read side effect on the status flags.
  assign statusClear = cpuStatRead ? (16'h0001 << cpuEp_reg) : 16'h0000;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      intSourceClear <= 16'h0000;
    end else if (clkEn) begin
      intSourceClear <= statusClear;
    end
  end

  // DMA transfer sequencing.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      dmaState_reg <= epbuf_pkg::DMA_IDLE;
      dmaEp_reg <= 4'h0;
      dmaBuf_reg <= 1'b0;
      dmaDir_reg <= 1'b0;
      dmaPtr_reg <= epbuf_pkg::FIRST_DATA_WORD;
      dmaLen_reg <= 16'h0000;
      dmaEot_reg <= 1'b0;
    end else if (clkEn) begin
      case (dmaState_reg)
        epbuf_pkg::DMA_IDLE: begin
          dmaEot_reg <= 1'b0;
          if (dmaStart) begin
            dmaEp_reg <= dmaEndpoint;
            dmaDir_reg <= dmaToBuffer;
            dmaBuf_reg <= statusFlat[dmaEndpoint*8 + epbuf_pkg::ST_CPU_BUFFER_SELECT_BIT];
            dmaPtr_reg <= epbuf_pkg::FIRST_DATA_WORD;
            dmaState_reg <= dmaToBuffer ? epbuf_pkg::DMA_RUN : epbuf_pkg::DMA_LOAD;
          end
        end
        epbuf_pkg::DMA_LOAD: begin
          if (dmaPortFree) begin
            dmaLen_reg <= locRdData;
            dmaPtr_reg <= epbuf_pkg::FIRST_DATA_WORD;
            dmaState_reg <= (locRdData == 16'h0000) ? epbuf_pkg::DMA_IDLE : epbuf_pkg::DMA_RUN;
          end
        end
        epbuf_pkg::DMA_RUN: begin
          if (transferEndSignal) begin
            // Early end: an IN buffer still goes out with what it holds.
            dmaEot_reg <= 1'b1;
            if (dmaDir_reg) begin
              dmaLen_reg <= 16'({dmaWordsDone, 1'b0});
              dmaState_reg <= epbuf_pkg::DMA_CLOSE;
            end else begin
              dmaState_reg <= epbuf_pkg::DMA_IDLE;
            end
          end else if (dmaGrant && dmaDir_reg) begin
            if (dmaEndOfBuf) begin
              dmaLen_reg <= 16'({dmaLastWord, 1'b0});
              dmaState_reg <= epbuf_pkg::DMA_CLOSE;
            end else begin
              dmaPtr_reg <= 10'(dmaPtr_reg + 10'h001);
            end
          end else if (dmaGrant) begin
            if (dmaEndOfPkt) begin
              if (dmaDouble) begin
                dmaBuf_reg <= ~dmaBuf_reg;
                dmaState_reg <= epbuf_pkg::DMA_LOAD;
              end else begin
                dmaState_reg <= epbuf_pkg::DMA_IDLE;
              end
            end else begin
              dmaPtr_reg <= 10'(dmaPtr_reg + 10'h001);
            end
          end
        end
        epbuf_pkg::DMA_CLOSE: begin
          if (dmaPortFree) begin
            dmaPtr_reg <= epbuf_pkg::FIRST_DATA_WORD;
            if (dmaDouble && !dmaEot_reg) begin
              dmaBuf_reg <= ~dmaBuf_reg;
              dmaState_reg <= epbuf_pkg::DMA_RUN;
            end else begin
              dmaState_reg <= epbuf_pkg::DMA_IDLE;
            end
          end
        end
        default: begin
          dmaState_reg <= epbuf_pkg::DMA_IDLE;
        end
      endcase
    end
  end

  // DMA answers and the ready-to-send notice to the serial engine.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      dmaDataOut <= 16'h0000;
      dmaAck <= 1'b0;
      dmaLast <= 1'b0;
      dmaBusy <= 1'b0;
      sendReq <= 1'b0;
      sendEndpoint <= 4'h0;
      sendBuffer <= 1'b0;
    end else if (clkEn) begin
      dmaAck <= dmaGrant && !transferEndSignal;
      dmaLast <= dmaGrant && !transferEndSignal && (dmaDir_reg ? dmaEndOfBuf : dmaEndOfPkt);
      dmaBusy <= dmaState_reg != epbuf_pkg::DMA_IDLE || dmaStart;
      if (dmaGrant && !dmaDir_reg) begin
        dmaDataOut <= locRdData;
      end
      sendReq <= dmaState_reg == epbuf_pkg::DMA_CLOSE && dmaPortFree;
      if (dmaState_reg == epbuf_pkg::DMA_CLOSE) begin
        sendEndpoint <= dmaEp_reg;
        sendBuffer <= dmaBuf_reg;
      end
    end
  end

  // A closed DMA buffer is marked full for the serial engine.
  assign fill0 = (dmaState_reg == epbuf_pkg::DMA_CLOSE && dmaPortFree && !dmaBuf_reg)
                 ? (16'h0001 << dmaEp_reg) : 16'h0000;
  assign fill1 = (dmaState_reg == epbuf_pkg::DMA_CLOSE && dmaPortFree && dmaBuf_reg)
                 ? (16'h0001 << dmaEp_reg) : 16'h0000;
  ep_status_bank u_status (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .clkEn(clkEn),
    .haltSet(haltSetEv),
    .haltClr(haltClrEv),
    .setupTok(setupTokEv),
    .full0Set(full0SetEv | fill0),
    .full0Clr(full0ClrEv),
    .full1Set(full1SetEv | fill1),
    .full1Clr(full1ClrEv),
    .toggleFlip(toggleFlipEv),
    .setupStore(setupStoreEv),
    .setupAck(setupAckEv),
    .overrunSet(overrunEv),
    .setupWriteBusy(setupWriteBusy),
    .bufSwitch(bufSwitchEv),
    .readClear(statusClear),
    .statusFlat(statusFlat)
  );
  ep_buffer_mem u_mem (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .clkEn(clkEn),
    .locAddr(locAddr),
    .locWe(locWe),
    .locWrData(locWrData),
    .locRdData(locRdData),
    .sieAddr(sieAddr),
    .sieWe(sieWe),
    .sieWrData(sieWrData),
    .sieRdData(sieRdData)
  );
endmodule

/* File: dma_agent.sv */
// Behavioural DMA agent that writes an incrementing word pattern into an IN buffer.
`timescale 1ns/10ps
module dma_agent (
  input wire logic clk_sys, // system clock
  input wire logic arst_n, // async reset, active low
  input wire logic go, // pulse: start requesting
  input wire logic dmaAck, // word moved
  input wire logic dmaLast, // last word of the buffer
  output logic dmaReq, // word request
  output logic [15:0] dmaDataIn // write data
);
  logic [15:0] count;
  // The next word is shown during the acknowledge cycle, since the request stays up back to back.
  assign dmaDataIn = 16'hA000 + count + {15'h0000, dmaAck};
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      dmaReq <= 1'b0;
      count <= 16'h0000;
    end else begin
      if (dmaAck) begin
        count <= count + 16'h0001;
      end
      dmaReq <= go | (dmaReq & !dmaLast);
    end
  end
endmodule

/* File: epbuf_sva.sv */
// Port-level assertions for the endpoint buffer command engine.
`timescale 1ns/10ps
module epbuf_sva (
  input wire logic clk_sys, arst_n, busRead, busWrite, commandDataSelect, busReadValid, busEndOfPacket,
  input wire logic dmaReq, dmaAck, dmaLast, dmaBusy, sendReq,
  input wire logic [15:0] busDataOut, intSourceClear
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  a_read_valid: assert property (busReadValid |-> $past(busRead && !commandDataSelect))
    else $error("read data without a data read strobe");
  a_cmd_quiet: assert property (busWrite && commandDataSelect |=> !busReadValid)
    else $error("command phase produced read data");
  a_clear_onehot: assert property (intSourceClear != 16'h0000 |-> $onehot(intSourceClear) && busReadValid)
    else $error("interrupt clear not one-hot with a status read");
  a_status_byte: assert property (intSourceClear != 16'h0000 |-> busDataOut[15:8] == 8'h00 && !busDataOut[0])
    else $error("status byte upper or reserved bits set");
  a_ack_cause: assert property (dmaAck |-> $past(dmaReq) && $past(dmaBusy))
    else $error("dma acknowledge without request");
  a_last_ack: assert property (dmaLast |-> dmaAck)
    else $error("dma last without acknowledge");
  a_send_close: assert property (sendReq |-> $past(dmaBusy))
    else $error("send request outside a transfer");
  a_eop_read: assert property ($rose(busEndOfPacket) |-> busReadValid)
    else $error("end of packet changed without a read");
endmodule
bind epbuf_cmd_engine epbuf_sva chk_i (.*);

/* File: endpoint_buffer_data_flow_commands_bench.sv */
// Self-checking bench for the endpoint buffer command engine.
`timescale 1ns/10ps
module endpoint_buffer_data_flow_commands_bench;
  logic clk_sys = 0, arst_n = 0, clkEn = 1, commandDataSelect = 0, busWrite = 0, busRead = 0, dmaStart = 0;
  logic dmaToBuffer = 1, dmaReq, transferEndSignal = 0, sieWe = 0, busReadValid, busEndOfPacket;
  logic dmaAck, dmaLast, dmaBusy, sendReq, sendBuffer;
  logic [15:0] busDataIn = 0, busDataOut, dmaDataIn, dmaDataOut, intSourceClear, sieWrData = 0, sieRdData;
  logic [15:0] epIsoMask = 0, epDoubleMask = 0, haltSetEv = 0, haltClrEv = 0, setupTokEv = 0, full0SetEv = 0;
  logic [15:0] full0ClrEv = 0, full1SetEv = 0, full1ClrEv = 0, toggleFlipEv = 0, setupStoreEv = 0;
  logic [15:0] setupAckEv = 0, overrunEv = 0, setupWriteBusy = 0, bufSwitchEv = 0;
  logic [159:0] epSizeFlat = {16{10'h008}};
  logic [3:0] dmaEndpoint = 4'h4, sendEndpoint;
  logic [14:0] sieAddr = 0;
  logic [15:0] pat [0:4] = '{16'h0004, 16'h2211, 16'h4433, 16'h6655, 16'h8877};
  int mismatches = 0, n_tests = 0, cycles = 0;
  epbuf_cmd_engine uut (.*);
  dma_agent agent (.clk_sys(clk_sys), .arst_n(arst_n), .go(dmaStart), .dmaAck(dmaAck), .dmaLast(dmaLast),
    .dmaReq(dmaReq), .dmaDataIn(dmaDataIn));
  initial forever #12.5 clk_sys = ~clk_sys;
  task wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      wrap_up;
    end
  end
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task bus(input logic s, input logic w, input logic r, input logic [15:0] d);
    {commandDataSelect, busWrite, busRead, busDataIn} = {s, w, r, d};
    @(posedge clk_sys) #1;
  endtask
  task rd(input logic [15:0] e, input logic eop);
    bus(0, 0, 1, 16'h0000);
    chk({15'h0000, busReadValid}, 16'h0001);
    chk(busDataOut, e);
    chk({15'h0000, busEndOfPacket}, {15'h0000, eop});
  endtask
  task t_status;
    bus(1, 1, 0, 16'h0055);
    rd(16'h0000, 0);
    {haltSetEv, full0SetEv, full1SetEv, toggleFlipEv, setupStoreEv, bufSwitchEv, overrunEv} = {7{16'h0020}};
    bus(0, 0, 0, 16'h0000);
    {haltSetEv, full0SetEv, full1SetEv, toggleFlipEv, setupStoreEv, bufSwitchEv, overrunEv} = '0;
    rd(16'h00FE, 0);
    chk(intSourceClear, 16'h0020);
    rd(16'h00F6, 0);
    $display("status test done");
  endtask
  task t_buffer;
    bus(1, 1, 0, 16'hFF03);
    for (int i = 0; i < 5; i++) bus(0, 1, 0, pat[i]);
    bus(0, 1, 0, 16'hDEAD);
    bus(1, 1, 0, 16'h0013);
    for (int i = 0; i < 5; i++) rd(pat[i], i == 2);
    rd(16'h0000, 0);
    bus(1, 1, 0, 16'h0011);
    bus(0, 0, 1, 16'h0000);
    chk({15'h0000, busReadValid}, 16'h0000);
    @(posedge clk_sys) #1;
    chk({15'h0000, busReadValid}, 16'h0000);
    $display("buffer test done");
  endtask
  task t_dma;
    dmaStart = 1;
    bus(0, 0, 0, 16'h0000);
    dmaStart = 0;
    for (int i = 0; i < 40 && sendReq !== 1'b1; i++) @(posedge clk_sys) #1;
    chk({10'h000, sendReq, sendBuffer, sendEndpoint}, 16'h0024);
    bus(1, 1, 0, 16'h0014);
    rd(16'h0008, 0);
    for (int i = 1; i < 5; i++) rd(16'hA000 + i - 1, i == 4);
    bus(1, 1, 0, 16'h0054);
    rd(16'h0020, 0);
    $display("dma test done");
  endtask
  task t_dma_read;
    {dmaToBuffer, dmaEndpoint, dmaStart} = {1'b0, 4'h3, 1'b1};
    sieAddr = 15'h2001;
    bus(0, 0, 0, 16'h0000);
    dmaStart = 0;
    chk(sieRdData, 16'hA000);
    repeat (2) @(posedge clk_sys) #1;
    chk(dmaDataOut, 16'h2211);
    chk({13'h0000, dmaBusy, dmaAck, dmaLast}, 16'h0006);
    @(posedge clk_sys) #1;
    chk(dmaDataOut, 16'h4433);
    chk({13'h0000, dmaBusy, dmaAck, dmaLast}, 16'h0007);
    $display("dma read test done");
  endtask
  initial begin
    repeat (10) @(posedge clk_sys);
    #1 arst_n = 1;
    t_status;
    t_buffer;
    t_dma;
    t_dma_read;
    wrap_up;
  end
endmodule
